// *** inc/mscs_pkg.sv ***
// Package for the eight-channel analog input scan sequencer
package mscs_pkg;

    // Channel count and widths
    localparam int unsigned NUM_CH    = 8;
    localparam int unsigned CH_W      = 3;
    localparam int unsigned DATA_W    = 16;

    // Spacing setting: steps of 25 ns, range 0 to 10 us
    localparam int unsigned STEP_NS       = 25;
    localparam int unsigned SPACE_MAX_NS  = 10000;
    localparam int unsigned SPACE_STEPS_MAX = SPACE_MAX_NS / STEP_NS;
    localparam int unsigned SPACE_W       = 9;

    // Default spacing for each variant, in ns
    localparam int unsigned DFLT_12BIT_NS = 2000;
    localparam int unsigned DFLT_HV_NS    = 1250;
    localparam logic [SPACE_W-1:0] DFLT_12BIT_STEPS =
        SPACE_W'(DFLT_12BIT_NS / STEP_NS);
    localparam logic [SPACE_W-1:0] DFLT_HV_STEPS =
        SPACE_W'(DFLT_HV_NS / STEP_NS);

    // Core clock: 125 MHz, 8 ns; cycles per 25 ns step rounded up
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned STEP_CYC =
        (STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned TICK_W = 3;

    // Setup conversions before a changed list
    localparam logic [1:0] SETUP_CONV_COUNT = 2'h2;

    // Reset values
    localparam logic [NUM_CH-1:0] LIST_RST = 8'h00;

    // Result word handed to the requester
    typedef struct packed {
        logic [CH_W-1:0]   chan;
        logic [DATA_W-1:0] data;
        logic              last;
    } mscs_result_t;

    // Command to the converter side
    typedef struct packed {
        logic [CH_W-1:0]   chan;
        logic              setup;
    } mscs_conv_t;

endpackage

// *** rtl/mscs_skid_buf.sv ***
// Two-entry valid/ready buffer for result words
`timescale 1ns/1ps
module mscs_skid_buf #(
    parameter int unsigned WIDTH = 20
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] mem_reg [2];
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       count_reg;
    logic             push;
    logic             pop;

    assign push = in_valid && in_ready;
    assign pop  = out_valid && out_ready;

    // Storage; only written on accepted words
    always_ff @(posedge core_clk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
            begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // Honest full and empty
    assign in_ready  = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign out_data  = mem_reg[rd_ptr_reg];

endmodule

// *** rtl/mscs_scan_seq.sv ***
// Scan sequencer for the eight-channel analog input module
// What this block does
// RQ1: Requested channels are converted in ascending channel number order.
// RQ2: A new channel set gets two setup conversions before its lowest channel.
// RQ3: The channel list of the last executed read is kept.
// RQ4: Setup conversions are skipped when the read repeats the stored list.
// RQ5: Expansion chassis, 12-bit variant: controller should use 2.1 us or more.
// RQ6: Expansion chassis, high-voltage variant: controller should use 2.1 us up.
// RQ7: Enforced minimum spacing comes from the static configuration value.
// RQ8: Controller sets actual spacing and reads no faster than the minimum.
// RQ9: Eight input channels, 0 to 7, each selectable in a read.
// RQ10: Minimum spacing configurable 0 to 10 us in 25 ns steps; the code times each step as 4 clocks (32 ns).
// RQ11: Default spacing is 2 us (12-bit) or 1.25 us (high-voltage).
// RQ12: One result per requested channel in scan order; setup results dropped.
`timescale 1ns/1ps
module mscs_scan_seq #(
    parameter bit                    HIGH_VOLTAGE = 1'b0,
    parameter logic [mscs_pkg::SPACE_W-1:0] MIN_SPACE_STEPS =
        HIGH_VOLTAGE ? mscs_pkg::DFLT_HV_STEPS
                     : mscs_pkg::DFLT_12BIT_STEPS
) (
    // Clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    // Read request from user logic
    input  wire logic                          req_valid,
    output logic                               req_ready,
    input  wire logic [mscs_pkg::NUM_CH-1:0]   req_chan_mask,
    // Results to user logic
    output logic                               res_valid,
    input  wire logic                          res_ready,
    output mscs_pkg::mscs_result_t             res_word,
    // Converter front end
    output logic                               conv_start,
    output mscs_pkg::mscs_conv_t               conv_cmd,
    input  wire logic                          conv_done,
    input  wire logic [mscs_pkg::DATA_W-1:0]   conv_data,
    // Status
    output logic                               setup_active,
    output logic      [mscs_pkg::NUM_CH-1:0]   stored_list
);

    localparam int unsigned RES_W = $bits(mscs_pkg::mscs_result_t);

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WAIT  = 4'h2,
        ST_START = 4'h4,
        ST_CONV  = 4'h8
    } mscs_state_t;

    mscs_state_t                         state_reg;
    logic [mscs_pkg::NUM_CH-1:0]         list_reg;
    logic [mscs_pkg::NUM_CH-1:0]         pend_reg;
    logic [1:0]                          setup_left_reg;
    logic [mscs_pkg::SPACE_W-1:0]        space_cnt_reg;
    logic [mscs_pkg::TICK_W-1:0]         tick_cnt_reg;
    logic                                step_en;
    logic                                space_ok;
    logic [mscs_pkg::CH_W-1:0]           low_ch;
    logic                                conv_start_reg;
    mscs_pkg::mscs_conv_t                conv_cmd_reg;
    logic                                cur_setup_reg;
    logic                                buf_in_valid;
    logic                                buf_in_ready;
    mscs_pkg::mscs_result_t              buf_in_data;
    logic                                buf_out_valid;
    logic [RES_W-1:0]                    buf_out_data;
    logic                                res_valid_reg;
    mscs_pkg::mscs_result_t              res_word_reg;

    ////////////////////////////////////////////////////////////////////////
    // Lowest pending channel; scan order ignores request ordering
    always_comb
    begin
        low_ch = '0;
        for (int i = mscs_pkg::NUM_CH - 1; i >= 0; i--)
        begin
            if (pend_reg[i])
            begin
                low_ch = mscs_pkg::CH_W'(i); // RQ1
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Spacing step enable every STEP_CYC core clocks (32 ns per 25 ns step)
    assign step_en = (tick_cnt_reg == mscs_pkg::TICK_W'(mscs_pkg::STEP_CYC - 1));

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || step_en || state_reg == ST_START)
        begin
            tick_cnt_reg <= '0;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    // Spacing counter restarts at every conversion start; it saturates
    // so a long idle gap leaves the next start free to go at once
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            space_cnt_reg <= MIN_SPACE_STEPS; // RQ11
        end
        else if (state_reg == ST_START)
        begin
            space_cnt_reg <= '0;
        end
        else if (step_en && !space_ok)
        begin
            space_cnt_reg <= space_cnt_reg + 1'b1;
        end
    end

    assign space_ok = (space_cnt_reg >= MIN_SPACE_STEPS); // RQ7 RQ10

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state machine
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= ST_IDLE;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                    if (req_valid && req_chan_mask != '0)
                    begin
                        state_reg <= ST_WAIT;
                    end
                ST_WAIT:
                    if (space_ok && buf_in_ready)
                    begin
                        state_reg <= ST_START;
                    end
                ST_START:
                    state_reg <= ST_CONV;
                ST_CONV:
                    if (conv_done)
                    begin
                        if (setup_left_reg == 2'h0 && cur_setup_reg == 1'b0
                            && pend_reg == '0)
                        begin
                            state_reg <= ST_IDLE;
                        end
                        else
                        begin
                            state_reg <= ST_WAIT;
                        end
                    end
            endcase
        end
    end

    // Stored list, pending set and setup count
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            list_reg       <= mscs_pkg::LIST_RST;
            pend_reg       <= '0;
            setup_left_reg <= 2'h0;
        end
        else if (state_reg == ST_IDLE && req_valid && req_chan_mask != '0)
        begin
            list_reg <= req_chan_mask; // RQ3 RQ9
            pend_reg <= req_chan_mask;
            if (req_chan_mask != list_reg)
            begin
                setup_left_reg <= mscs_pkg::SETUP_CONV_COUNT; // RQ2 RQ4
            end
            else
            begin
                setup_left_reg <= 2'h0; // RQ4
            end
        end
        else if (state_reg == ST_START)
        begin
            if (setup_left_reg != 2'h0)
            begin
                setup_left_reg <= setup_left_reg - 2'h1; // RQ2
            end
            else
            begin
                pend_reg[low_ch] <= 1'b0; // RQ1
            end
        end
    end

    // Converter command; setup conversions aim at the lowest channel
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            conv_start_reg <= 1'b0;
            conv_cmd_reg   <= '0;
            cur_setup_reg  <= 1'b0;
        end
        else
        begin
            // Pulse in the cycle the command appears, so the front end
            // never latches the channel of the previous conversion
            conv_start_reg <= (state_reg == ST_START); // RQ7
            if (state_reg == ST_START)
            begin
                conv_cmd_reg.chan  <= low_ch;
                conv_cmd_reg.setup <= (setup_left_reg != 2'h0);
                cur_setup_reg      <= (setup_left_reg != 2'h0);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Results: setup conversions are discarded
    assign buf_in_valid     = (state_reg == ST_CONV) && conv_done
                              && !cur_setup_reg; // RQ12
    assign buf_in_data.chan = conv_cmd_reg.chan;
    assign buf_in_data.data = conv_data;
    assign buf_in_data.last = (pend_reg == '0);

    mscs_skid_buf #(
        .WIDTH     (RES_W)
    ) u_buf (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .in_valid  (buf_in_valid),
        .in_ready  (buf_in_ready),
        .in_data   (buf_in_data),
        .out_valid (buf_out_valid),
        .out_ready (!res_valid_reg || res_ready),
        .out_data  (buf_out_data)
    );

    // Output register stage keeps every output on a flip-flop
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            res_valid_reg <= 1'b0;
            res_word_reg  <= '0;
        end
        else if (!res_valid_reg || res_ready)
        begin
            res_valid_reg <= buf_out_valid; // RQ12
            res_word_reg  <= buf_out_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered status and request handshake
    logic req_ready_reg;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            req_ready_reg <= 1'b0;
        end
        else
        begin
            req_ready_reg <= (state_reg == ST_IDLE) && req_valid
                             && req_chan_mask != '0 && !req_ready_reg;
        end
    end

    assign req_ready    = req_ready_reg;
    assign res_valid    = res_valid_reg;
    assign res_word     = res_word_reg;
    assign conv_start   = conv_start_reg;
    assign conv_cmd     = conv_cmd_reg;
    assign setup_active = cur_setup_reg;
    assign stored_list  = list_reg;

endmodule

// *** testbench/mscs_scan_seq_chk.sv ***
// Port checker for the scan sequencer
`timescale 1ns/1ps
module mscs_scan_seq_chk #(
    parameter logic [mscs_pkg::SPACE_W-1:0] MIN_SPACE_STEPS = 9'h002
) (
    // Clock and reset
    input wire logic                  core_clk,
    input wire logic                  rst_n,
    // Request and result sides
    input wire logic                  req_ready,
    input wire logic                  res_valid,
    input wire logic                  res_ready,
    input wire mscs_pkg::mscs_result_t res_word,
    // Converter side and status
    input wire logic                  conv_start,
    input wire mscs_pkg::mscs_conv_t  conv_cmd,
    input wire logic [7:0]            stored_list
);
    int         gap_reg;
    logic [1:0] nset_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Lowest or highest channel of a list
    function automatic logic [2:0] edge_ch(input logic [7:0] m, input bit hi);
        bit f;
        f = 1'b0;
        edge_ch = 3'h0;
        for (int i = 0; i < 8; i++)
            if (m[i] && (hi || !f))
            begin
                edge_ch = 3'(i);
                f = 1'b1;
            end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Cycles since last start; saturates so reset counts as spaced
    always_ff @(posedge core_clk)
        if (!rst_n)
            gap_reg <= 1000;
        else if (conv_start)
            gap_reg <= 1;
        else if (gap_reg < 1000)
            gap_reg <= gap_reg + 1;

    // Setup starts since the last taken read
    always_ff @(posedge core_clk)
        if (!rst_n || req_ready)
            nset_reg <= 2'h0;
        else if (conv_start && conv_cmd.setup)
            nset_reg <= nset_reg + 2'h1;

    ////////////////////////////////////////////////////////////////////////
    a_space_min: assert property (
        conv_start |-> gap_reg * 8 >= int'(MIN_SPACE_STEPS) * 25)
        else $error("conversion start too soon");
    a_setup_chan: assert property (
        conv_start && conv_cmd.setup |->
        conv_cmd.chan == edge_ch(stored_list, 1'b0))
        else $error("setup on wrong channel");
    a_setup_pair: assert property (
        conv_start && !conv_cmd.setup |-> nset_reg inside {2'h0, 2'h2})
        else $error("setup count not zero or two");
    a_conv_listed: assert property (
        conv_start |-> stored_list[conv_cmd.chan])
        else $error("conversion of unrequested channel");
    a_res_listed: assert property (
        res_valid |-> stored_list[res_word.chan])
        else $error("result of unrequested channel");
    a_res_last: assert property (
        res_valid && res_word.last |->
        res_word.chan == edge_ch(stored_list, 1'b1))
        else $error("last flag on wrong channel");
    a_res_hold: assert property (
        res_valid && !res_ready |=> res_valid && $stable(res_word))
        else $error("result dropped while stalled");
    a_list_take: assert property (
        $changed(stored_list) |-> req_ready || $past(req_ready))
        else $error("stored list changed without a read");
endmodule

bind mscs_scan_seq mscs_scan_seq_chk #(
    .MIN_SPACE_STEPS(MIN_SPACE_STEPS)
) chk_u (
    .core_clk(core_clk), .rst_n(rst_n), .req_ready(req_ready),
    .res_valid(res_valid), .res_ready(res_ready), .res_word(res_word),
    .conv_start(conv_start), .conv_cmd(conv_cmd),
    .stored_list(stored_list)
);

// *** testbench/mscs_conv_model.sv ***
// Converter front end model answering start pulses
`timescale 1ns/1ps
module mscs_conv_model (
    // Clock
    input  wire logic                 core_clk,
    // Start side
    input  wire logic                 conv_start,
    input  wire mscs_pkg::mscs_conv_t conv_cmd,
    input  wire logic [3:0]           lat,
    // Answer side
    output logic                      conv_done,
    output logic [15:0]               conv_data
);
    logic [3:0]           cnt_reg = 4'h0;
    mscs_pkg::mscs_conv_t cmd_reg;

    initial conv_done = 1'b0;
    initial conv_data = 16'h0000;

    // Done after lat cycles; setup words carry a top-bit marker so a leak
    // shows up; data toggles outside the pulse so stale reads are caught
    always @(posedge core_clk)
    begin
        conv_done <= 1'b0;
        conv_data <= ~conv_data;
        if (conv_start)
        begin
            cnt_reg <= lat;
            cmd_reg <= conv_cmd;
        end
        else if (cnt_reg != 4'h0)
        begin
            cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h1)
            begin
                conv_done <= 1'b1;
                conv_data <= {cmd_reg.setup, 12'h000, cmd_reg.chan};
            end
        end
    end
endmodule

// *** testbench/test_multichannel_adc_scan_sequencer.sv ***
// Self-checking bench for the scan sequencer
`timescale 1ns/1ps
module test_multichannel_adc_scan_sequencer;
    logic                   core_clk, rst_n, req_valid, req_ready;
    logic                   res_valid, res_ready, conv_start, conv_done;
    logic                   setup_active;
    logic [7:0]             req_chan_mask, stored_list;
    logic [3:0]             lat;
    logic [15:0]            conv_data;
    mscs_pkg::mscs_result_t res_word;
    mscs_pkg::mscs_conv_t   conv_cmd;
    int                     n_fail, check_count, n_setup;
    // Expansion chassis minimum for either variant: 2.1 us = 84 steps
    localparam logic [8:0]  EXP_STEPS = 9'h054;
    logic                   x_req_valid, x_req_ready;
    logic                   x_conv_start, x_conv_done;
    logic [15:0]            x_conv_data;
    mscs_pkg::mscs_conv_t   x_conv_cmd;

    mscs_scan_seq #(.MIN_SPACE_STEPS(9'h002)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_chan_mask(req_chan_mask),
        .res_valid(res_valid), .res_ready(res_ready), .res_word(res_word),
        .conv_start(conv_start), .conv_cmd(conv_cmd),
        .conv_done(conv_done), .conv_data(conv_data),
        .setup_active(setup_active), .stored_list(stored_list));
    mscs_conv_model model_u (
        .core_clk(core_clk), .conv_start(conv_start), .conv_cmd(conv_cmd),
        .lat(lat), .conv_done(conv_done), .conv_data(conv_data));

    // Second copy configured for the expansion chassis
    mscs_scan_seq #(.HIGH_VOLTAGE(1'b1), .MIN_SPACE_STEPS(EXP_STEPS))
        dut_exp (
        .core_clk(core_clk), .rst_n(rst_n), .req_valid(x_req_valid),
        .req_ready(x_req_ready), .req_chan_mask(req_chan_mask),
        .res_valid(), .res_ready(res_ready), .res_word(),
        .conv_start(x_conv_start), .conv_cmd(x_conv_cmd),
        .conv_done(x_conv_done), .conv_data(x_conv_data),
        .setup_active(), .stored_list());
    mscs_conv_model model_exp (
        .core_clk(core_clk), .conv_start(x_conv_start),
        .conv_cmd(x_conv_cmd), .lat(lat),
        .conv_done(x_conv_done), .conv_data(x_conv_data));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Count setup starts seen on the converter side
    always @(posedge core_clk)
        if (conv_start && conv_cmd.setup && setup_active)
            n_setup++;

    ////////////////////////////////////////////////////////////////////////
    task test_done;
        if (n_fail == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task check(input bit ok, input string msg);
        check_count++;
        if (!ok)
        begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // One falling edge with a bound on the whole wait
    task automatic step(inout int k);
        @(negedge core_clk);
        k++;
        if (k > 2000)
        begin
            n_fail++;
            test_done;
        end
    endtask

    // One read, held until acknowledged; results drained with optional stall
    task automatic do_read(input logic [7:0] m, input bit stall, input int ns);
        int k;
        k = 0;
        n_setup = 0;
        req_chan_mask = m;
        req_valid = 1'b1;
        while (req_ready !== 1'b1)
            step(k);
        req_valid = 1'b0;
        for (int ch = 0; ch < 8; ch++)
            if (m[ch])
            begin
                while (!(res_valid === 1'b1 && res_ready))
                begin
                    step(k);
                    res_ready = !stall || k[1];
                end
                check(res_word.chan === 3'(ch), "bad result channel");
                check(res_word.data === 16'(ch), "bad result data");
                check(res_word.last === (m >> (ch + 1) == 8'h00), "bad last");
                step(k);
            end
        res_ready = 1'b0;
        repeat (20) step(k);
        check(res_valid === 1'b0, "extra result word");
        check(n_setup == ns, "wrong setup count");
        check(stored_list === m, "stored list wrong");
        check(setup_active === 1'b0, "setup flag stuck");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task t_first;
        lat = 4'h2;
        do_read(8'h81, 1'b0, 2);
    endtask

    task t_repeat;
        lat = 4'h6;
        do_read(8'h81, 1'b0, 0);
    endtask

    task t_all;
        lat = 4'h1;
        do_read(8'hff, 1'b1, 2);
    endtask

    task automatic t_zero;
        int k, seen;
        k = 0;
        seen = 0;
        req_chan_mask = 8'h00;
        req_valid = 1'b1;
        repeat (30)
        begin
            step(k);
            seen += int'(req_ready !== 1'b0) + int'(conv_start !== 1'b0);
        end
        req_valid = 1'b0;
        check(seen == 0, "empty read taken");
    endtask

    task t_change;
        do_read(8'h80, 1'b0, 2);
        do_read(8'h80, 1'b1, 0);
        do_read(8'h01, 1'b0, 2);
    endtask

    // Expansion copy: new list, so two setups and one real start, each
    // spaced by at least the configured 2.1 us
    task automatic t_expand;
        int k, gap, starts;
        k = 0;
        gap = 0;
        starts = 0;
        req_chan_mask = 8'h01;
        x_req_valid = 1'b1;
        while (x_req_ready !== 1'b1)
            step(k);
        x_req_valid = 1'b0;
        while (starts < 3)
        begin
            step(k);
            gap++;
            if (x_conv_start === 1'b1)
            begin
                if (starts > 0)
                    check(gap * 8 >= int'(EXP_STEPS) * 25, "gap short");
                starts++;
                gap = 0;
            end
        end
    endtask

    // Stored list must already be clear right after the sync reset
    initial
    begin
        rst_n = 1'b0;
        x_req_valid = 1'b0;
        req_valid = 1'b0;
        req_chan_mask = 8'h00;
        res_ready = 1'b0;
        lat = 4'h2;
        n_fail = 0;
        check_count = 0;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        check(stored_list === 8'h00, "list not cleared");
        t_first;
        t_repeat;
        t_all;
        t_zero;
        t_change;
        t_expand;
        test_done;
    end
endmodule
